// [common/swm_pkg.sv]
// Constants, field layouts and carrier types of the socket window register bank.
package swm_pkg;

  localparam int NUM_WIN = 5;
  localparam int AV_ADDR_W = 8;
  localparam int AV_DATA_W = 32;
  localparam int IDX_W = 6;
  localparam int REG_W = 8;
  localparam int CARD_ADDR_W = 14;
  localparam int HOST_ADDR_W = 12;
  localparam int WIN_SEL_W = 3;

  // Register indexes; the byte address on the bus is four times the index.
  localparam logic [IDX_W-1:0] IDX_WIN0_UPPER = 6'h15;
  localparam logic [IDX_W-1:0] IDX_WIN1_UPPER = 6'h1d;
  localparam logic [IDX_W-1:0] IDX_WIN2_UPPER = 6'h25;
  localparam logic [IDX_W-1:0] IDX_WIN3_UPPER = 6'h2d;
  localparam logic [IDX_W-1:0] IDX_WIN4_UPPER = 6'h35;
  localparam logic [IDX_W-1:0] IDX_MISC_ONE = 6'h16;
  localparam logic [IDX_W-1:0] IDX_FIFO_CTRL = 6'h17;
  localparam int IDX_LSB = 2;

  // Window upper offset register fields.
  localparam int WIN_OFS_MSB = 5;
  localparam int WIN_ATTR_BIT = 6;
  localparam int WIN_WP_BIT = 7;

  // Socket misc control one fields.
  localparam int MISC_VSENSE_BIT = 0;
  localparam int MISC_VCC3_BIT = 1;
  localparam int MISC_PULSE_MGMT_BIT = 2;
  localparam int MISC_PULSE_SYS_BIT = 3;
  localparam int MISC_SPKR_BIT = 4;
  localparam int MISC_INPACK_BIT = 7;
  localparam logic [REG_W-1:0] MISC_RW_MASK = 8'hfe;

  // Write FIFO control fields.
  localparam int FIFO_EMPTY_BIT = 7;
  localparam int SCRATCH_W = 7;

  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  localparam logic [SCRATCH_W-1:0] SCRATCH_RESET = 7'h00;

  // Pulse train: high for PULSE_HIGH_CYC cycles out of 2**PULSE_CNT_W.
  localparam int PULSE_CNT_W = 4;
  localparam logic [PULSE_CNT_W-1:0] PULSE_HIGH_CYC = 4'h4;
  localparam logic [PULSE_CNT_W-1:0] PULSE_CNT_ONE = 4'h1;
  localparam logic [PULSE_CNT_W-1:0] PULSE_CNT_RESET = 4'h0;

  // Positions of the asynchronous card pins in the synchroniser vector.
  localparam int PIN_VS1 = 0;
  localparam int PIN_VS2 = 1;
  localparam int PIN_PGOOD = 2;
  localparam int PIN_CDET = 3;
  localparam int PIN_SPKR_N = 4;
  localparam int PIN_INPACK_N = 5;
  localparam int PIN_IREQ_N = 6;
  localparam int NUM_PINS = 7;
  // Active-low card pins reset to their idle high level, so no false
  // interrupt, speaker or acknowledge is seen while the synchroniser fills.
  localparam logic [NUM_PINS-1:0] PIN_RESET = 7'h70;

  typedef struct packed {
    logic active;
    logic io_read;
    logic [WIN_SEL_W-1:0] win;
    logic [REG_W-1:0] ofs_low;
    logic [HOST_ADDR_W-1:0] host_addr;
  } swm_access_s;

  typedef struct packed {
    logic [NUM_WIN-1:0][REG_W-1:0] win;
    logic [REG_W-1:0] misc;
    logic [SCRATCH_W-1:0] scratch;
    logic [NUM_PINS-1:0] pin_meta;
    logic [NUM_PINS-1:0] pin_sync;
    logic [PULSE_CNT_W-1:0] mgmt_cnt;
    logic [PULSE_CNT_W-1:0] sys_cnt;
    logic av_wait;
    logic [REG_W-1:0] av_rdata;
    logic [CARD_ADDR_W-1:0] card_addr;
    logic attr_sel;
    logic write_allow;
    logic sup5;
    logic sup3;
    logic mgmt_out;
    logic sys_out;
    logic spk;
    logic spk_oe;
    logic host_drive;
    logic flush;
  } swm_state_s;

endpackage

// [core/swm_socket_ctrl.sv]
// Per-socket window offset, misc control and write FIFO control registers.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Upper offset register low six bits hold card offset bits 13 to 8.
// - Card address is host address plus the hit window's offset quantity.
// - Five upper offset registers at 15h,1Dh,25h,2Dh,35h, reset to zero.
// - Window attribute bit set asserts attribute select on its accesses.
// - Window write-protect bit set suppresses card writes through it.
// - Write protect acts only in memory card interface mode.
// - Misc bit 0 reads voltage sense: 0 is 3.3 V-only card.
// - Misc bit 1 picks the 3.3 V or 5 V supply enable.
// - Misc bit 2 makes management interrupts a pulse train, else level.
// - Misc bit 3 makes system interrupts a pulse train, else level.
// - Misc bit 4 drives speaker output from card speaker, else floats.
// - Misc bit 7 lets input acknowledge gate host data drive on reads.
// - Writing 1 to FIFO bit 7 flushes the write FIFO; 0 does nothing.
// - FIFO bit 7 reads 1 when the write FIFO is empty.
// - FIFO flushes on power-good low, card removal or supply off.
module swm_socket_ctrl
  import swm_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic [AV_ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [AV_DATA_W-1:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [AV_DATA_W-1:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire swm_access_s I_ACCESS,
  input wire logic I_MEM_CARD_MODE,
  input wire logic I_VCC_POWER,
  input wire logic I_MGMT_IRQ,
  input wire logic I_FIFO_EMPTY,
  input wire logic I_VOLTAGE_SENSE_ONE,
  input wire logic I_VOLTAGE_SENSE_TWO,
  input wire logic I_POWER_GOOD_INPUT,
  input wire logic I_CARD_DETECT,
  input wire logic I_CARD_SPEAKER_N,
  input wire logic I_CARD_INPACK_N,
  input wire logic I_CARD_IREQ_N,
  output logic [CARD_ADDR_W-1:0] O_CARD_ADDR,
  output logic O_ATTR_SELECT,
  output logic O_CARD_WRITE_ALLOW,
  output logic O_SUPPLY_EN_5V,
  output logic O_SUPPLY_EN_3V,
  output logic O_MANAGEMENT_INTERRUPT_OUT,
  output logic O_SYSTEM_INTERRUPT_LINE,
  output logic O_SPEAKER_OUTPUT,
  output logic O_SPEAKER_OUTPUT_OE,
  output logic O_HOST_DATA_DRIVE,
  output logic O_FIFO_FLUSH
);

  swm_state_s st_ff;
  swm_state_s nxt_st;

  logic [IDX_W-1:0] idx;
  logic [WIN_SEL_W-1:0] wsel;
  logic bus_req;
  logic wr_take;
  logic flush_wr;
  logic vsense;
  logic win_hit;
  logic [REG_W-1:0] hit_reg;
  logic [REG_W-1:0] rd_val;
  logic [NUM_PINS-1:0] pins_in;

  // Maps a register index to a window number, or NUM_WIN when none.
  function automatic logic [WIN_SEL_W-1:0] win_of_index(
    input logic [IDX_W-1:0] i
  );
    logic [WIN_SEL_W-1:0] w;
    w = WIN_SEL_W'(NUM_WIN);
    unique case (i)
      IDX_WIN0_UPPER: w = 3'h0;
      IDX_WIN1_UPPER: w = 3'h1;
      IDX_WIN2_UPPER: w = 3'h2;
      IDX_WIN3_UPPER: w = 3'h3;
      IDX_WIN4_UPPER: w = 3'h4;
      default: w = WIN_SEL_W'(NUM_WIN);
    endcase
    return w;
  endfunction

  // Level mode follows the request; pulse mode gates it with the counter.
  function automatic logic pulse_out(
    input logic pulse_mode,
    input logic req,
    input logic [PULSE_CNT_W-1:0] cnt
  );
    return req & (~pulse_mode | (cnt < PULSE_HIGH_CYC));
  endfunction

  assign pins_in = {I_CARD_IREQ_N, I_CARD_INPACK_N, I_CARD_SPEAKER_N,
                    I_CARD_DETECT, I_POWER_GOOD_INPUT,
                    I_VOLTAGE_SENSE_TWO, I_VOLTAGE_SENSE_ONE};

  always_comb begin
    nxt_st = st_ff;
    idx = I_AVS_ADDRESS[AV_ADDR_W-1:IDX_LSB];
    wsel = win_of_index(idx);
    bus_req = I_AVS_READ | I_AVS_WRITE;
    wr_take = I_AVS_WRITE & ~st_ff.av_wait & I_AVS_BYTEENABLE[0];
    flush_wr = 1'b0;
    // A 3.3 V-only card pulls one sense pin low.
    vsense = st_ff.pin_sync[PIN_VS1] & st_ff.pin_sync[PIN_VS2];
    rd_val = REG_RESET;
    hit_reg = REG_RESET;
    win_hit = I_ACCESS.active & (I_ACCESS.win < WIN_SEL_W'(NUM_WIN));

    nxt_st.pin_meta = pins_in;
    nxt_st.pin_sync = st_ff.pin_meta;

    if (wsel < WIN_SEL_W'(NUM_WIN)) begin
      rd_val = st_ff.win[wsel];
    end else if (idx == IDX_MISC_ONE) begin
      rd_val = st_ff.misc & MISC_RW_MASK;
      rd_val[MISC_VSENSE_BIT] = vsense;
    end else if (idx == IDX_FIFO_CTRL) begin
      rd_val = {I_FIFO_EMPTY, st_ff.scratch};
    end

    // One wait state: the answer comes the cycle after the request.
    if (st_ff.av_wait && bus_req) begin
      nxt_st.av_wait = 1'b0;
      if (I_AVS_READ) begin
        nxt_st.av_rdata = rd_val;
      end
    end else begin
      nxt_st.av_wait = 1'b1;
    end

    if (wr_take) begin
      if (wsel < WIN_SEL_W'(NUM_WIN)) begin
        nxt_st.win[wsel] = I_AVS_WRITEDATA[REG_W-1:0];
      end else if (idx == IDX_MISC_ONE) begin
        nxt_st.misc = I_AVS_WRITEDATA[REG_W-1:0] & MISC_RW_MASK;
      end else if (idx == IDX_FIFO_CTRL) begin
        nxt_st.scratch = I_AVS_WRITEDATA[SCRATCH_W-1:0];
        flush_wr = I_AVS_WRITEDATA[FIFO_EMPTY_BIT];
      end
    end

    // Loss of power or card must not leave stale posted writes behind.
    nxt_st.flush = flush_wr | ~st_ff.pin_sync[PIN_PGOOD] |
                   ~st_ff.pin_sync[PIN_CDET] | ~I_VCC_POWER;

    if (win_hit) begin
      hit_reg = st_ff.win[I_ACCESS.win];
    end
    nxt_st.card_addr = {2'b00, I_ACCESS.host_addr} +
                       {hit_reg[WIN_OFS_MSB:0], I_ACCESS.ofs_low};
    nxt_st.attr_sel = win_hit & hit_reg[WIN_ATTR_BIT];
    nxt_st.write_allow = ~(win_hit & I_MEM_CARD_MODE &
                           hit_reg[WIN_WP_BIT]);

    nxt_st.sup5 = I_VCC_POWER & ~st_ff.misc[MISC_VCC3_BIT];
    nxt_st.sup3 = I_VCC_POWER & st_ff.misc[MISC_VCC3_BIT];

    // Counters run only while a request is pending so each train starts high.
    nxt_st.mgmt_cnt = I_MGMT_IRQ ? st_ff.mgmt_cnt + PULSE_CNT_ONE :
                      PULSE_CNT_RESET;
    nxt_st.sys_cnt = ~st_ff.pin_sync[PIN_IREQ_N] ?
                     st_ff.sys_cnt + PULSE_CNT_ONE : PULSE_CNT_RESET;
    nxt_st.mgmt_out = pulse_out(st_ff.misc[MISC_PULSE_MGMT_BIT],
                                I_MGMT_IRQ, st_ff.mgmt_cnt);
    nxt_st.sys_out = pulse_out(st_ff.misc[MISC_PULSE_SYS_BIT],
                               ~st_ff.pin_sync[PIN_IREQ_N], st_ff.sys_cnt);

    // With one socket the exclusive-OR reduces to that socket's signal.
    nxt_st.spk = ~st_ff.pin_sync[PIN_SPKR_N];
    nxt_st.spk_oe = st_ff.misc[MISC_SPKR_BIT];
    nxt_st.host_drive = I_ACCESS.io_read &
                        (~st_ff.misc[MISC_INPACK_BIT] |
                         ~st_ff.pin_sync[PIN_INPACK_N]);
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      st_ff.win <= '0;
      st_ff.misc <= REG_RESET;
      st_ff.scratch <= SCRATCH_RESET;
      st_ff.pin_meta <= PIN_RESET;
      st_ff.pin_sync <= PIN_RESET;
      st_ff.mgmt_cnt <= PULSE_CNT_RESET;
      st_ff.sys_cnt <= PULSE_CNT_RESET;
      st_ff.av_wait <= 1'b1;
      st_ff.av_rdata <= REG_RESET;
      st_ff.card_addr <= '0;
      st_ff.attr_sel <= 1'b0;
      st_ff.write_allow <= 1'b1;
      st_ff.sup5 <= 1'b0;
      st_ff.sup3 <= 1'b0;
      st_ff.mgmt_out <= 1'b0;
      st_ff.sys_out <= 1'b0;
      st_ff.spk <= 1'b0;
      st_ff.spk_oe <= 1'b0;
      st_ff.host_drive <= 1'b0;
      st_ff.flush <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign O_AVS_READDATA = {{(AV_DATA_W-REG_W){1'b0}}, st_ff.av_rdata};
  assign O_AVS_WAITREQUEST = st_ff.av_wait;
  assign O_CARD_ADDR = st_ff.card_addr;
  assign O_ATTR_SELECT = st_ff.attr_sel;
  assign O_CARD_WRITE_ALLOW = st_ff.write_allow;
  assign O_SUPPLY_EN_5V = st_ff.sup5;
  assign O_SUPPLY_EN_3V = st_ff.sup3;
  assign O_MANAGEMENT_INTERRUPT_OUT = st_ff.mgmt_out;
  assign O_SYSTEM_INTERRUPT_LINE = st_ff.sys_out;
  assign O_SPEAKER_OUTPUT = st_ff.spk;
  assign O_SPEAKER_OUTPUT_OE = st_ff.spk_oe;
  assign O_HOST_DATA_DRIVE = st_ff.host_drive;
  assign O_FIFO_FLUSH = st_ff.flush;

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);

  a_offset_reset_zero: assert property (
    $past(I_RST) |-> (st_ff.win == '0)
  ) else $error("window offset registers not zero after reset");

  a_card_addr_sum: assert property (
    (I_ACCESS.active && I_ACCESS.win == 3'h2) |=>
      (O_CARD_ADDR == $past({2'b00, I_ACCESS.host_addr} +
                            {st_ff.win[2][WIN_OFS_MSB:0], I_ACCESS.ofs_low}))
  ) else $error("card address is not host address plus offset");

  a_attr_follows_bit: assert property (
    (I_ACCESS.active && I_ACCESS.win == 3'h2) |=>
      (O_ATTR_SELECT == $past(st_ff.win[2][WIN_ATTR_BIT]))
  ) else $error("attribute select does not follow window bit");

  a_attr_no_window: assert property (
    !win_hit |=> !O_ATTR_SELECT
  ) else $error("attribute select active without a window hit");

  a_write_inhibit: assert property (
    (win_hit && I_MEM_CARD_MODE && hit_reg[WIN_WP_BIT]) |=>
      !O_CARD_WRITE_ALLOW
  ) else $error("protected window allowed a card write");

  a_wp_mode_only: assert property (
    !I_MEM_CARD_MODE |=> O_CARD_WRITE_ALLOW
  ) else $error("write protect acted outside memory card mode");

  a_supply_select: assert property (
    I_VCC_POWER |=> (O_SUPPLY_EN_3V == $past(st_ff.misc[MISC_VCC3_BIT]))
                    && (O_SUPPLY_EN_5V != O_SUPPLY_EN_3V)
  ) else $error("supply enable selection wrong");

  a_mgmt_level: assert property (
    (!st_ff.misc[MISC_PULSE_MGMT_BIT] && I_MGMT_IRQ) |=>
      O_MANAGEMENT_INTERRUPT_OUT
  ) else $error("level management interrupt not driven");

  a_mgmt_pulse_gap: assert property (
    (st_ff.misc[MISC_PULSE_MGMT_BIT] && st_ff.mgmt_cnt >= PULSE_HIGH_CYC) |=>
      !O_MANAGEMENT_INTERRUPT_OUT
  ) else $error("management pulse train not low in its gap");

  a_sys_level: assert property (
    (!st_ff.misc[MISC_PULSE_SYS_BIT] && !st_ff.pin_sync[PIN_IREQ_N]) |=>
      O_SYSTEM_INTERRUPT_LINE
  ) else $error("level system interrupt not driven");

  a_sys_pulse_gap: assert property (
    (st_ff.misc[MISC_PULSE_SYS_BIT] && st_ff.sys_cnt >= PULSE_HIGH_CYC) |=>
      !O_SYSTEM_INTERRUPT_LINE
  ) else $error("pulse train not low in its gap");

  a_vsense_read: assert property (
    (st_ff.av_wait && I_AVS_READ && idx == IDX_MISC_ONE) |=>
      (O_AVS_READDATA[MISC_VSENSE_BIT] == $past(vsense))
  ) else $error("voltage sense bit misread");

  a_speaker_drive: assert property (
    ##1 (O_SPEAKER_OUTPUT_OE == $past(st_ff.misc[MISC_SPKR_BIT]))
  ) else $error("speaker enable does not follow control bit");

  a_inpack_gate: assert property (
    (st_ff.misc[MISC_INPACK_BIT] && st_ff.pin_sync[PIN_INPACK_N]) |=>
      !O_HOST_DATA_DRIVE
  ) else $error("host data driven without input acknowledge");

  a_flush_on_write: assert property (
    (wr_take && idx == IDX_FIFO_CTRL &&
     I_AVS_WRITEDATA[FIFO_EMPTY_BIT]) |=> O_FIFO_FLUSH
  ) else $error("flush write did not flush");

  a_flush_on_power: assert property (
    (!st_ff.pin_sync[PIN_PGOOD] || !I_VCC_POWER) |=> O_FIFO_FLUSH
  ) else $error("fifo not flushed on power loss");

  a_flush_on_removal: assert property (
    !st_ff.pin_sync[PIN_CDET] |=> O_FIFO_FLUSH
  ) else $error("fifo not flushed on card removal");

  a_empty_read: assert property (
    (st_ff.av_wait && I_AVS_READ && idx == IDX_FIFO_CTRL) |=>
      (O_AVS_READDATA[FIFO_EMPTY_BIT] == $past(I_FIFO_EMPTY))
  ) else $error("fifo empty status misread");

  a_bus_answer: assert property (
    (bus_req && st_ff.av_wait) |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST
  ) else $error("bus answer not one cycle");

  a_window_write: assert property (
    (wr_take && wsel == 3'h1) |=>
      (st_ff.win[1] == $past(I_AVS_WRITEDATA[REG_W-1:0]))
  ) else $error("window register write lost");

  c_window_write: cover property (
    wr_take && wsel == 3'h4
  );
  c_sys_pulse_train: cover property (
    st_ff.misc[MISC_PULSE_SYS_BIT] && O_SYSTEM_INTERRUPT_LINE ##1
      !O_SYSTEM_INTERRUPT_LINE [*2]
  );
  c_protected_access: cover property (
    win_hit && I_MEM_CARD_MODE && hit_reg[WIN_WP_BIT]
  );
  c_flush_by_write: cover property (
    wr_take && idx == IDX_FIFO_CTRL && I_AVS_WRITEDATA[FIFO_EMPTY_BIT]
  );
  c_card_removed: cover property (
    !st_ff.pin_sync[PIN_CDET] && I_VCC_POWER
  );

endmodule

`default_nettype wire

// [dv/swm_card_model.sv]
// Behavioural PC Card as seen at the socket pins.
`timescale 1ns/1ps
`default_nettype none
module swm_card_model (
  input wire logic i_present,
  input wire logic [1:0] i_vsense,
  input wire logic i_speaker,
  input wire logic i_ireq,
  input wire logic i_inpack,
  output logic o_vs1,
  output logic o_vs2,
  output logic o_cdet,
  output logic o_spkr_n,
  output logic o_inpack_n,
  output logic o_ireq_n
);
  // A removed card leaves every pin but card detect, which reads low, to the socket pull-ups.
  assign o_cdet = i_present;
  assign o_vs1 = i_present ? i_vsense[0] : 1'b1;
  assign o_vs2 = i_present ? i_vsense[1] : 1'b1;
  assign o_spkr_n = i_present ? !i_speaker : 1'b1;
  assign o_inpack_n = i_present ? !i_inpack : 1'b1;
  assign o_ireq_n = i_present ? !i_ireq : 1'b1;
endmodule
`default_nettype wire

// [dv/swm_socket_ctrl_tb.sv]
// Register-level testbench of the socket window register bank.
`timescale 1ns/1ps
`default_nettype none
module swm_socket_ctrl_tb;
  import swm_pkg::*;
  logic clk, rst, rd, wr, mode, vcc, mgmt, fempty, pg, pres, spk, ireq, ipk;
  logic vs1, vs2, cdet, spk_n, ipk_n, irq_n, waitreq, attr, wallow;
  logic s5, s3, mint, sint, spo, spoe, hdrv, flush;
  logic [1:0] vs;
  logic [3:0] be;
  logic [7:0] addr, q;
  logic [31:0] wdata, rdata;
  logic [13:0] caddr;
  swm_access_s acc;
  int mismatches, tests_run, i, cm, cs, cf;

  swm_card_model card (.i_present(pres), .i_vsense(vs), .i_speaker(spk),
    .i_ireq(ireq), .i_inpack(ipk), .o_vs1(vs1), .o_vs2(vs2), .o_cdet(cdet),
    .o_spkr_n(spk_n), .o_inpack_n(ipk_n), .o_ireq_n(irq_n));

  swm_socket_ctrl uut (.I_CLOCK(clk), .I_RST(rst), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
    .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(waitreq), .I_ACCESS(acc), .I_MEM_CARD_MODE(mode),
    .I_VCC_POWER(vcc), .I_MGMT_IRQ(mgmt), .I_FIFO_EMPTY(fempty),
    .I_VOLTAGE_SENSE_ONE(vs1), .I_VOLTAGE_SENSE_TWO(vs2),
    .I_POWER_GOOD_INPUT(pg), .I_CARD_DETECT(cdet),
    .I_CARD_SPEAKER_N(spk_n), .I_CARD_INPACK_N(ipk_n),
    .I_CARD_IREQ_N(irq_n), .O_CARD_ADDR(caddr), .O_ATTR_SELECT(attr),
    .O_CARD_WRITE_ALLOW(wallow), .O_SUPPLY_EN_5V(s5), .O_SUPPLY_EN_3V(s3),
    .O_MANAGEMENT_INTERRUPT_OUT(mint), .O_SYSTEM_INTERRUPT_LINE(sint),
    .O_SPEAKER_OUTPUT(spo), .O_SPEAKER_OUTPUT_OE(spoe),
    .O_HOST_DATA_DRIVE(hdrv), .O_FIFO_FLUSH(flush));

  // The clock never stops, so pulse trains keep running.
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic done(input string nm);
    $display("test %s ended", nm);
  endtask

  // Holds the request until waitrequest is sampled low, then releases.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    if (waitreq !== 1'b0) begin
      mismatches++;
      results();
    end
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {8'h00, e}, {8'h00, q});
  endtask

  // Outputs are sampled at an edge, long after the inputs last moved.
  task automatic settle();
    repeat (5) @(posedge clk);
  endtask

  task automatic count(input int n);
    cm = 0;
    cs = 0;
    cf = 0;
    repeat (n) begin
      @(posedge clk);
      cm += int'(mint === 1'b1);
      cs += int'(sint === 1'b1);
      cf += int'(flush === 1'b1);
    end
  endtask

  initial begin
    rst = 1'b1; rd = 1'b0; wr = 1'b0; addr = 8'h00; wdata = 32'h0;
    be = 4'h1; acc = '0; mode = 1'b1; vcc = 1'b1; mgmt = 1'b0;
    fempty = 1'b0; pg = 1'b1; pres = 1'b1; vs = 2'b11; spk = 1'b0;
    ireq = 1'b0; ipk = 1'b0; mismatches = 0; tests_run = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    settle();
    for (i = 0; i < NUM_WIN; i++) begin
      rdchk("window reset", 8'h54 + 8'(i * 32), 8'h00);
    end
    rdchk("misc reset", 8'h58, 8'h01);
    rdchk("fifo reset", 8'h5c, 8'h00);
    done("reset");
    for (i = 0; i < NUM_WIN; i++) begin
      bus(1'b1, 8'h54 + 8'(i * 32), 8'h10 + 8'(i));
    end
    bus(1'b1, 8'h00, 8'hff);
    be <= 4'h0;
    bus(1'b1, 8'h54, 8'hee);
    be <= 4'h1;
    for (i = 0; i < NUM_WIN; i++) begin
      rdchk("window copy", 8'h54 + 8'(i * 32), 8'h10 + 8'(i));
    end
    rdchk("unmapped", 8'h00, 8'h00);
    done("window registers");
    bus(1'b1, 8'h94, 8'h7f);
    acc <= '{1'b1, 1'b0, 3'd2, 8'h01, 12'hfff};
    settle();
    // The card address is 14 bits wide, so the sum wraps past bit 13.
    chk("card addr", 16'h0f00, {2'b00, caddr});
    chk("attr on", 16'h1, {15'h0, attr});
    chk("allow wp0", 16'h1, {15'h0, wallow});
    bus(1'b1, 8'h94, 8'h3f);
    acc.ofs_low <= 8'h00;
    settle();
    chk("card addr two", 16'h0eff, {2'b00, caddr});
    chk("attr off", 16'h0, {15'h0, attr});
    bus(1'b1, 8'h94, 8'hff);
    settle();
    chk("allow wp1", 16'h0, {15'h0, wallow});
    mode <= 1'b0;
    settle();
    chk("allow io mode", 16'h1, {15'h0, wallow});
    mode <= 1'b1;
    acc.win <= 3'd5;
    settle();
    chk("attr no window", 16'h0, {15'h0, attr});
    chk("allow no window", 16'h1, {15'h0, wallow});
    acc.win <= 3'd2;
    done("window access");
    vs <= 2'b00;
    bus(1'b1, 8'h58, 8'h03);
    settle();
    rdchk("misc sense", 8'h58, 8'h02);
    chk("supplies 3v", 16'h1, {14'h0, s5, s3});
    vs <= 2'b11;
    bus(1'b1, 8'h58, 8'h00);
    settle();
    chk("supplies 5v", 16'h2, {14'h0, s5, s3});
    chk("speaker off", 16'h0, {15'h0, spoe});
    acc.io_read <= 1'b1;
    settle();
    chk("drive no ack", 16'h1, {15'h0, hdrv});
    bus(1'b1, 8'h58, 8'h90);
    spk <= 1'b1;
    settle();
    chk("speaker on", 16'h3, {14'h0, spoe, spo});
    chk("drive wait ack", 16'h0, {15'h0, hdrv});
    spk <= 1'b0;
    ipk <= 1'b1;
    settle();
    chk("speaker low", 16'h2, {14'h0, spoe, spo});
    chk("drive on ack", 16'h1, {15'h0, hdrv});
    done("misc control");
    for (i = 0; i < 2; i++) begin
      bus(1'b1, 8'h58, i ? 8'h0c : 8'h00);
      mgmt <= 1'b1;
      ireq <= 1'b1;
      settle();
      count(32);
      chk("mgmt irq", i ? 16'd8 : 16'd32, 16'(cm));
      chk("sys irq", i ? 16'd8 : 16'd32, 16'(cs));
      mgmt <= 1'b0;
      ireq <= 1'b0;
      settle();
      chk("irq idle", 16'h0, {14'h0, mint, sint});
    end
    done("interrupts");
    // Scratch bits are used with no card access in progress.
    acc.active <= 1'b0;
    fempty <= 1'b1;
    bus(1'b1, 8'h5c, 8'h25);
    count(6);
    chk("no flush on 0", 16'h0, 16'(cf));
    rdchk("fifo empty", 8'h5c, 8'ha5);
    fempty <= 1'b0;
    rdchk("fifo busy", 8'h5c, 8'h25);
    bus(1'b1, 8'h5c, 8'h80);
    count(6);
    chk("flush pulse", 16'h1, 16'(cf));
    for (i = 0; i < 3; i++) begin
      pg <= (i != 0);
      pres <= (i != 1);
      vcc <= (i != 2);
      settle();
      chk("flush cause", 16'h1, {15'h0, flush});
      pg <= 1'b1;
      pres <= 1'b1;
      vcc <= 1'b1;
      settle();
      chk("flush clear", 16'h0, {15'h0, flush});
    end
    done("write fifo");
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule
`default_nettype wire
